// ===== design/dmc_defs.vh
// Constants for the direct-mapped parity cache: address split, control bits,
// error bits, register offsets, trap vector and bus response codes.
// Assumes inclusion by design files only.
`ifndef DMC_DEFS_VH
`define DMC_DEFS_VH

// Address split: 9-bit label, 12-bit index, 1-bit byte select.
`define DMC_ADDR_W      22
`define DMC_LABEL_W     9
`define DMC_INDEX_W     12
`define DMC_ENTRIES     4096
`define DMC_IDX_LSB     1
`define DMC_LBL_LSB     13
// Top 8 Kb of the 22-bit space is the I/O page.
`define DMC_IOPAGE_TOP  9'h1FF

// Control register bit positions.
`define DMC_C_NOINT     0
`define DMC_C_FMISS_LO  2
`define DMC_C_FMISS_HI  3
`define DMC_C_ABTEN     7
`define DMC_C_FLUSH     8
`define DMC_C_BYPASS    9
`define DMC_CTRL_RW     16'h06FF

// Error status bit positions.
`define DMC_E_ABORT     15
`define DMC_E_HIGH      7
`define DMC_E_LOW       6
`define DMC_E_TAG       5

// Register byte offsets on the AXI4-Lite bus.
`define DMC_OFF_CTRL    4'h0
`define DMC_OFF_ERR     4'h4
`define DMC_OFF_HIT     4'h8
`define DMC_OFF_STAT    4'hC

// Trap vector reported with abort and interrupt.
`define DMC_VECTOR      9'h04C

// Bus response codes.
`define DMC_RESP_OK     2'h0
`define DMC_RESP_SLVERR 2'h2

`endif

// ===== design/dmc_cache.v
// Direct-mapped write-through cache with parity, control and status over
// AXI4-Lite. Processor references arrive on a request port and the system
// bus memory side on a memory port; DMA writes are snooped.
// Assumes one 100 MHz clock and synchronous inputs.
`timescale 1ns/1ns
`default_nettype none
`include "dmc_defs.vh"

module dmc_cache #(
  parameter ADDR_W  = `DMC_ADDR_W,
  parameter INDEX_W = `DMC_INDEX_W,
  parameter LABEL_W = `DMC_LABEL_W
) (
  // Clock and reset
  input  wire               aclk,
  input  wire               aresetn,
  // AXI4-Lite register slave
  input  wire [3:0]         s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [3:0]         s_axi_araddr,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  // Processor request port
  input  wire               cpu_req,
  input  wire               cpu_write,
  input  wire               cpu_byte,
  input  wire [ADDR_W-1:0]  cpu_addr,
  input  wire [15:0]        cpu_wdata,
  output wire               cpu_ready,
  output reg                cpu_done,
  output reg  [15:0]        cpu_rdata,
  output reg                cpu_abort,
  output reg                cpu_intr,
  output reg  [8:0]         cpu_vector,
  // System bus memory port
  output reg                mem_req,
  output reg                mem_write,
  output reg                mem_byte,
  output reg  [ADDR_W-1:0]  mem_addr,
  output reg  [15:0]        mem_wdata,
  input  wire               mem_ack,
  input  wire [17:0]        bus_data_address_lines,
  input  wire               bus_data_in_strobe,
  // DMA snoop port
  input  wire               dma_write,
  input  wire [ADDR_W-1:0]  dma_addr,
  // Status
  output wire               flush_busy
);

  // ************************************************************
  // Storage and parity helpers
  // ************************************************************
  localparam ENTRIES = 1 << INDEX_W;
  localparam ENT_W   = LABEL_W + 1 + 1 + 8 + 1 + 8 + 1;
  localparam [INDEX_W-1:0] LAST_IDX = {INDEX_W{1'b1}};

  // Entry layout: tag, tag parity, valid, high, high par, low, low par.
  reg [ENT_W-1:0] store [0:ENTRIES-1];

  function [INDEX_W-1:0] idx_of;
    input [ADDR_W-1:0] a;
    idx_of = a[`DMC_IDX_LSB +: INDEX_W];
  endfunction

  function [LABEL_W-1:0] lbl_of;
    input [ADDR_W-1:0] a;
    lbl_of = a[`DMC_LBL_LSB +: LABEL_W];
  endfunction

  // Even parity bit for a tag or low byte, odd for the high byte.
  function [ENT_W-1:0] make_ent;
    input [LABEL_W-1:0] t;
    input               v;
    input [15:0]        d;
    input               bad_tag;
    input               bad_dat;
    make_ent = {t, (^t) ^ bad_tag, v, d[15:8], ~(^d[15:8]) ^ bad_dat,
                d[7:0], (^d[7:0]) ^ bad_dat};
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  reg [15:0] ctrl_reg;
  reg [15:0] err_reg;
  reg [15:0] hit_reg;
  reg        flushing_reg;
  reg [INDEX_W-1:0] fidx_reg;

  wire force_miss = ctrl_reg[`DMC_C_FMISS_LO] | ctrl_reg[`DMC_C_FMISS_HI];
  wire bypass     = ctrl_reg[`DMC_C_BYPASS];
  assign flush_busy = flushing_reg;

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  reg        aw_got_reg;
  reg        w_got_reg;
  reg [3:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;

  assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire       wr_fire = aw_got_reg & w_got_reg;
  wire       wr_ctrl = wr_fire & (aw_addr_reg == `DMC_OFF_CTRL);
  wire       wr_err  = wr_fire & (aw_addr_reg == `DMC_OFF_ERR);
  wire       wr_ok   = wr_ctrl | wr_err | (aw_addr_reg == `DMC_OFF_HIT) |
                       (aw_addr_reg == `DMC_OFF_STAT);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      aw_addr_reg  <= 4'h0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DMC_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `DMC_RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `DMC_RESP_OK : `DMC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `DMC_RESP_OK;
        case (s_axi_araddr)
          `DMC_OFF_CTRL: s_axi_rdata <= {16'h0000,
                                         ctrl_reg & `DMC_CTRL_RW};
          `DMC_OFF_ERR:  s_axi_rdata <= {16'h0000, err_reg};
          `DMC_OFF_HIT:  s_axi_rdata <= {16'h0000, hit_reg};
          `DMC_OFF_STAT: s_axi_rdata <= {31'h00000000, flushing_reg};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DMC_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Reference sequencer
  // ************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_LOOK = 2'h1;
  localparam ST_MEM  = 2'h2;

  reg [1:0]        state_reg;
  reg              op_wr_reg;
  reg              op_byte_reg;
  reg [ADDR_W-1:0] op_addr_reg;
  reg [15:0]       op_wdata_reg;
  reg [ENT_W-1:0]  ent_reg;
  reg              hit_op_reg;
  reg              cerr_reg;
  reg [2:0]        cerr_kind_reg;
  reg              dma_pend_reg;
  reg [ADDR_W-1:0] dma_addr_reg;

  assign cpu_ready = (state_reg == ST_IDLE) & ~flushing_reg & ~dma_pend_reg;

  // Fields of the entry read in the look-up cycle.
  wire [LABEL_W-1:0] e_tag = ent_reg[ENT_W-1 -: LABEL_W];
  wire        e_tp  = ent_reg[19];
  wire        e_v   = ent_reg[18];
  wire [7:0]  e_hi  = ent_reg[17:10];
  wire        e_hp  = ent_reg[9];
  wire [7:0]  e_lo  = ent_reg[8:1];
  wire        e_lp  = ent_reg[0];
  wire        tag_bad = e_v & ((^e_tag) != e_tp);
  wire        hi_bad  = e_v & (~(^e_hi) != e_hp);
  wire        lo_bad  = e_v & ((^e_lo) != e_lp);
  wire        iopage  = lbl_of(op_addr_reg) == `DMC_IOPAGE_TOP;
  wire        match   = e_v & (e_tag == lbl_of(op_addr_reg));
  wire        perr    = ~force_miss & match &
                        (tag_bad | hi_bad | lo_bad);
  wire        hit     = match & ~perr & ~iopage & ~force_miss;

  wire [15:0] wr_merge = !op_byte_reg ? op_wdata_reg :
                         op_addr_reg[0] ? {op_wdata_reg[15:8], e_lo} :
                                          {e_hi, op_wdata_reg[7:0]};

  wire flush_w = wr_ctrl & w_strb_reg[1] & w_data_reg[`DMC_C_FLUSH];

  // DMA snoop look-up registers the entry once the sequencer is idle and not flushing, and compares it the next cycle.
  reg [ENT_W-1:0] dent_reg;
  reg             dcheck_reg;
  wire            dma_hit = dent_reg[18] &
                  (dent_reg[ENT_W-1 -: LABEL_W] == lbl_of(dma_addr_reg));

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg     <= ST_IDLE;
      ctrl_reg      <= 16'h0000;
      err_reg       <= 16'h0000;
      hit_reg       <= 16'h0000;
      flushing_reg  <= 1'b1;
      fidx_reg      <= {INDEX_W{1'b0}};
      op_wr_reg     <= 1'b0;
      op_byte_reg   <= 1'b0;
      op_addr_reg   <= {ADDR_W{1'b0}};
      op_wdata_reg  <= 16'h0000;
      ent_reg       <= {ENT_W{1'b0}};
      dent_reg      <= {ENT_W{1'b0}};
      dcheck_reg    <= 1'b0;
      hit_op_reg    <= 1'b0;
      cerr_reg      <= 1'b0;
      cerr_kind_reg <= 3'h0;
      dma_pend_reg  <= 1'b0;
      dma_addr_reg  <= {ADDR_W{1'b0}};
      mem_req       <= 1'b0;
      mem_write     <= 1'b0;
      mem_byte      <= 1'b0;
      mem_addr      <= {ADDR_W{1'b0}};
      mem_wdata     <= 16'h0000;
      cpu_done      <= 1'b0;
      cpu_rdata     <= 16'h0000;
      cpu_abort     <= 1'b0;
      cpu_intr      <= 1'b0;
      cpu_vector    <= 9'h000;
    end
    else
    begin
      cpu_done  <= 1'b0;
      cpu_abort <= 1'b0;
      cpu_intr  <= 1'b0;
      if (wr_ctrl)
        ctrl_reg <= (w_data_reg[15:0] & `DMC_CTRL_RW);
      if (wr_err)
        err_reg <= 16'h0000;
      if (flush_w)
      begin
        flushing_reg <= 1'b1;
        fidx_reg     <= {INDEX_W{1'b0}};
      end
      else if (flushing_reg)
      begin
        // Invalid entries still carry good parity so later checks pass.
        store[fidx_reg] <= make_ent({LABEL_W{1'b0}}, 1'b0, 16'h0000,
                                    1'b0, 1'b0);
        fidx_reg <= fidx_reg + 1'b1;
        if (fidx_reg == LAST_IDX)
          flushing_reg <= 1'b0;
      end
      // DMA writes are captured, then looked up while the CPU waits.
      dcheck_reg <= 1'b0;
      if (dma_write && !dma_pend_reg)
      begin
        dma_pend_reg <= 1'b1;
        dma_addr_reg <= dma_addr;
      end
      else if (dma_pend_reg && state_reg == ST_IDLE && !flushing_reg)
      begin
        if (!dcheck_reg)
        begin
          dent_reg   <= store[idx_of(dma_addr_reg)];
          dcheck_reg <= 1'b1;
        end
        else
        begin
          if (dma_hit)
            store[idx_of(dma_addr_reg)] <= make_ent(dent_reg[ENT_W-1 -:
              LABEL_W], 1'b0, 16'h0000, 1'b0, 1'b0);
          dma_pend_reg <= 1'b0;
        end
      end
      case (state_reg)
        ST_IDLE:
        begin
          if (cpu_req && cpu_ready)
          begin
            op_wr_reg    <= cpu_write;
            op_byte_reg  <= cpu_byte;
            op_addr_reg  <= cpu_addr;
            op_wdata_reg <= cpu_wdata;
            ent_reg      <= store[idx_of(cpu_addr)];
            state_reg    <= ST_LOOK;
          end
        end
        ST_LOOK:
        begin
          hit_op_reg    <= hit;
          cerr_reg      <= perr & ~bypass;
          cerr_kind_reg <= {hi_bad, lo_bad, tag_bad};
          if (!op_wr_reg && hit && !bypass)
          begin
            cpu_rdata <= {e_hi, e_lo};
            cpu_done  <= 1'b1;
            hit_reg   <= {hit_reg[14:0], 1'b1};
            state_reg <= ST_IDLE;
          end
          else
          begin
            mem_req   <= 1'b1;
            mem_write <= op_wr_reg;
            mem_byte  <= op_byte_reg;
            mem_addr  <= op_addr_reg;
            mem_wdata <= op_wdata_reg;
            if (!op_wr_reg)
              hit_reg <= {hit_reg[14:0], 1'b0};
            state_reg <= ST_MEM;
          end
        end
        ST_MEM:
        begin
          if (mem_ack)
          begin
            mem_req   <= 1'b0;
            mem_write <= 1'b0;
            cpu_done  <= 1'b1;
            state_reg <= ST_IDLE;
            if (!op_wr_reg)
              cpu_rdata <= bus_data_address_lines[15:0];
            if (!op_wr_reg && !bus_data_in_strobe &&
                bus_data_address_lines[16] && bus_data_address_lines[17])
            begin
              cpu_abort  <= 1'b1;
              cpu_vector <= `DMC_VECTOR;
              err_reg[`DMC_E_ABORT] <= 1'b1;
            end
            else if (cerr_reg && !err_reg[`DMC_E_ABORT] &&
                     err_reg[7:5] == 3'h0)
            begin
              // Later errors stay silent so a bad cell cannot loop traps.
              cpu_vector <= `DMC_VECTOR;
              if (ctrl_reg[`DMC_C_ABTEN])
              begin
                cpu_abort <= 1'b1;
                err_reg[`DMC_E_ABORT] <= 1'b1;
                err_reg[7:5] <= cerr_kind_reg;
              end
              else if (!ctrl_reg[`DMC_C_NOINT])
              begin
                cpu_intr <= 1'b1;
                err_reg[7:5] <= 3'h7;
              end
            end
            if (force_miss || iopage)
              ;
            else if (bypass)
            begin
              if (hit_op_reg)
                store[idx_of(op_addr_reg)] <= make_ent(e_tag, 1'b0,
                  16'h0000, 1'b0, 1'b0);
            end
            else if (!op_wr_reg || !op_byte_reg || hit_op_reg)
              // Byte-write misses skip this branch.
              store[idx_of(op_addr_reg)] <= make_ent(
                lbl_of(op_addr_reg), 1'b1,
                op_wr_reg ? wr_merge : bus_data_address_lines[15:0],
                ctrl_reg[10], ctrl_reg[6]);
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== sim/dmc_cache_assertions.sv
// Checker for the parity cache: processor, memory and flush timing.
// Assumes it is bound into dmc_cache and sees one clock domain.
`timescale 1ns/1ns
`default_nettype none
module dmc_cache_chk #(
  parameter ADDR_W = 22
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Processor side
  input wire logic              cpu_req,
  input wire logic              cpu_write,
  input wire logic              cpu_ready,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic              cpu_done,
  input wire logic [15:0]       cpu_rdata,
  input wire logic              cpu_abort,
  input wire logic              cpu_intr,
  input wire logic [8:0]        cpu_vector,
  // Memory side and status
  input wire logic              mem_req,
  input wire logic              mem_write,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              mem_ack,
  input wire logic [17:0]       bus_data_address_lines,
  input wire logic              bus_data_in_strobe,
  input wire logic              flush_busy
);
  // ****************
  // Helpers
  // ****************
  // The flush is far too long for a repetition, so a counter measures it.
  int fcnt;
  always @(posedge aclk)
    if (!aresetn || !flush_busy)
      fcnt <= 0;
    else
      fcnt <= fcnt + 1;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd_take;
    cpu_req && cpu_ready && !cpu_write;
  endsequence
  sequence s_wr_take;
    cpu_req && cpu_ready && cpu_write;
  endsequence
  sequence s_mem_rd;
    mem_ack && mem_req && !mem_write;
  endsequence

  // ****************
  // Properties
  // ****************
  property p_lookup;
    s_rd_take |-> ##2 (cpu_done || mem_req);
  endproperty
  a_lookup: assert property (p_lookup)
    else $error("read neither answered nor sent to memory");
  property p_io_miss;
    s_rd_take ##0 (cpu_addr[ADDR_W-1:ADDR_W-9] == 9'h1FF)
      |-> ##2 (mem_req && !cpu_done);
  endproperty
  a_io_miss: assert property (p_io_miss)
    else $error("I/O page read served from cache");
  property p_wr_through;
    s_wr_take |-> ##2 (mem_req && mem_write &&
      mem_addr[ADDR_W-1:1] == $past(cpu_addr[ADDR_W-1:1], 2));
  endproperty
  a_wr_through: assert property (p_wr_through)
    else $error("write not passed to memory");
  property p_fill;
    s_mem_rd ##0 (bus_data_address_lines[17:16] != 2'h3)
      |=> cpu_done && cpu_rdata == $past(bus_data_address_lines[15:0]);
  endproperty
  a_fill: assert property (p_fill)
    else $error("memory data not returned");
  property p_mem_abort;
    s_mem_rd ##0 (!bus_data_in_strobe && bus_data_address_lines[17:16] == 2'h3)
      |=> cpu_done && cpu_abort;
  endproperty
  a_mem_abort: assert property (p_mem_abort)
    else $error("memory parity abort missing");
  property p_vector;
    (cpu_abort || cpu_intr) |-> cpu_done && cpu_vector == 9'h04C;
  endproperty
  a_vector: assert property (p_vector)
    else $error("trap without done or wrong vector");
  property p_flush_block;
    flush_busy |-> !cpu_ready;
  endproperty
  a_flush_block: assert property (p_flush_block)
    else $error("processor accepted during flush");
  property p_flush_len;
    $fell(flush_busy) |-> fcnt inside {[4095:4097]};
  endproperty
  a_flush_len: assert property (p_flush_len)
    else $error("flush length wrong");
endmodule

bind dmc_cache dmc_cache_chk #(.ADDR_W(ADDR_W)) u_chk (
  .aclk, .aresetn, .cpu_req, .cpu_write, .cpu_ready, .cpu_addr, .cpu_done,
  .cpu_rdata, .cpu_abort, .cpu_intr, .cpu_vector, .mem_req, .mem_write,
  .mem_addr, .mem_ack, .bus_data_address_lines, .bus_data_in_strobe,
  .flush_busy
);
`default_nettype wire

// ===== sim/dmc_mem_model.sv
// Main memory model: answers each held mem_req with one mem_ack.
// Assumes the cache keeps its request steady until mem_ack.
`timescale 1ns/1ns
`default_nettype none
module dmc_mem_model (
  // Clock
  input  wire logic        aclk,
  // Memory port
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic        mem_byte,
  input  wire logic [21:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack = 1'b0,
  output logic [17:0]      bus_data_address_lines = 18'h00000,
  output logic             bus_data_in_strobe = 1'b0,
  // Bench control
  input  wire logic [1:0]  perr,
  input  wire logic [3:0]  lat,
  output int               n_acc = 0
);
  logic [15:0] mem [logic [20:0]];
  logic [15:0] w;
  logic [3:0]  cnt = 4'h0;

  function automatic logic [15:0] word(input logic [21:0] a);
    return mem.exists(a[21:1]) ? mem[a[21:1]] : a[16:1] ^ 16'h5A3C;
  endfunction

  always @(posedge aclk)
  begin
    mem_ack <= 1'b0;
    bus_data_in_strobe <= 1'b0;
    // Idle lines toggle so that stale read data can never look valid.
    bus_data_address_lines <= ~bus_data_address_lines;
    if (mem_req && !mem_ack)
    begin
      if (cnt < lat)
      begin
        cnt <= cnt + 4'h1;
        bus_data_in_strobe <= !mem_write;
      end
      else
      begin
        cnt <= 4'h0;
        mem_ack <= 1'b1;
        n_acc <= n_acc + 1;
        w = word(mem_addr);
        if (!mem_write)
          bus_data_address_lines <= {perr, w};
        else if (!mem_byte)
          mem[mem_addr[21:1]] = mem_wdata;
        else if (mem_addr[0])
          mem[mem_addr[21:1]] = {mem_wdata[15:8], w[7:0]};
        else
          mem[mem_addr[21:1]] = {w[15:8], mem_wdata[7:0]};
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb_dmc_cache.sv
// Bench for the parity cache: register, processor and DMA tasks.
// Assumes the design, the memory model and the checker are compiled.
`timescale 1ns/1ns
`default_nettype none
module tb_dmc_cache;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, perr = 2'h0;
  logic cpu_req = 1'b0, cpu_write = 1'b0, cpu_byte = 1'b0, dma_write = 1'b0;
  logic [21:0] cpu_addr = 22'h0, dma_addr = 22'h0, mem_addr, x;
  logic [15:0] cpu_wdata = 16'h0, cpu_rdata, mem_wdata, got_d;
  logic cpu_ready, cpu_done, cpu_abort, cpu_intr, got_ab, got_it;
  logic mem_req, mem_write, mem_byte, mem_ack, bus_data_in_strobe;
  logic flush_busy;
  logic [8:0] cpu_vector;
  logic [17:0] bus_data_address_lines;
  logic [3:0] lat = 4'h0;
  logic [7:0] cm [4] = '{8'h00, 8'h01, 8'h80, 8'h81};
  logic [31:0] rv;
  int n_acc, n0, failures = 0, n_tests = 0, cyc = 0;
  localparam logic [21:0] A = 22'h000100, B = 22'h000201, C = 22'h000400;
  localparam logic [21:0] IO = 22'h3FE010;

  dmc_cache dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cpu_req, .cpu_write, .cpu_byte, .cpu_addr, .cpu_wdata, .cpu_ready,
    .cpu_done, .cpu_rdata, .cpu_abort, .cpu_intr, .cpu_vector, .mem_req,
    .mem_write, .mem_byte, .mem_addr, .mem_wdata, .mem_ack,
    .bus_data_address_lines, .bus_data_in_strobe, .dma_write, .dma_addr,
    .flush_busy
  );
  dmc_mem_model mm (
    .aclk, .mem_req, .mem_write, .mem_byte, .mem_addr, .mem_wdata, .mem_ack,
    .bus_data_address_lines, .bus_data_in_strobe, .perr, .lat, .n_acc
  );

  always #5 aclk = ~aclk;

  // ****************
  // Tasks
  // ****************
  function automatic logic [15:0] mf(input logic [21:0] a);
    return a[16:1] ^ 16'h5A3C;
  endfunction
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'h0);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] m, e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rv = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'h0);
    s_axi_rready <= 1'b0;
    chk(rv & m, e);
  endtask
  task automatic cpu_op(input logic w, b, input logic [21:0] a,
                        input logic [15:0] d);
    @(posedge aclk);
    cpu_req <= 1'b1;
    cpu_write <= w;
    cpu_byte <= b;
    cpu_addr <= a;
    cpu_wdata <= d;
    n0 = n_acc;
    do @(posedge aclk); while (!cpu_ready);
    cpu_req <= 1'b0;
    do @(posedge aclk); while (!cpu_done);
    got_d = cpu_rdata;
    got_ab = cpu_abort;
    got_it = cpu_intr;
  endtask
  task automatic rd(input logic [21:0] a, input logic [15:0] e, input int n);
    cpu_op(1'b0, 1'b0, a, 16'h0);
    chk(32'(got_d), 32'(e));
    chk(32'(n_acc - n0), 32'(n));
  endtask
  task automatic wr(input logic [21:0] a, input logic [15:0] d,
                    input logic b);
    cpu_op(1'b1, b, a, d);
    chk(32'(n_acc - n0), 32'h1);
  endtask
  task automatic dma(input logic [21:0] a);
    @(posedge aclk);
    dma_addr <= a;
    dma_write <= 1'b1;
    @(posedge aclk);
    dma_write <= 1'b0;
  endtask
  task automatic wait_flush;
    do @(posedge aclk); while (flush_busy !== 1'b0);
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      failures++;
      final_report();
    end
  end

  // ****************
  // Tests
  // ****************
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    wait_flush();
    rchk(4'h0, 32'hFFFFFFFF, 32'h0);
    rd(A, mf(A), 1);
    rd(A, mf(A), 0);
    // Bit 0 holds the most recent read: miss then hit reads back 01.
    rchk(4'h8, 32'h3, 32'h1);
    wr(A, 16'h1234, 1'b0);
    rd(A, 16'h1234, 0);
    wr(B, 16'hAB00, 1'b1);
    rd(B, 16'hAB00 | (mf(B) & 16'h00FF), 1);
    wr(C, 16'hC0DE, 1'b0);
    rd(C, 16'hC0DE, 0);
    $display("test hit, miss and writes ended");
    dma(A);
    rd(A, 16'h1234, 1);
    dma(C + 22'h002000);
    rd(C, 16'hC0DE, 0);
    lat <= 4'h5;
    repeat (2) rd(IO, mf(IO), 1);
    $display("test dma and io page ended");
    for (int i = 2; i < 4; i++)
    begin
      axi_wr(4'h0, 32'h1 << i);
      rd(C, 16'hC0DE, 1);
      axi_wr(4'h0, 32'h0);
      rd(C, 16'hC0DE, 0);
    end
    axi_wr(4'h0, 32'h200);
    rd(C, 16'hC0DE, 1);
    axi_wr(4'h0, 32'h0);
    rd(C, 16'hC0DE, 1);
    axi_wr(4'h0, 32'h7FF);
    rchk(4'h0, 32'hFFFFFFFF, 32'h6FF);
    rchk(4'hC, 32'h1, 32'h1);
    wait_flush();
    axi_wr(4'h0, 32'h0);
    rd(C, 16'hC0DE, 1);
    $display("test modes and flush ended");
    for (int p = 1; p < 4; p++)
    begin
      perr <= 2'(p);
      cpu_op(1'b0, 1'b0, IO, 16'h0);
      chk(32'(got_ab), 32'(p == 3));
    end
    perr <= 2'h0;
    rchk(4'h4, 32'h8000, 32'h8000);
    for (int i = 0; i < 4; i++)
    begin
      x = 22'h001000 + 22'(i * 2);
      axi_wr(4'h4, 32'h0);
      axi_wr(4'h0, 32'h40);
      rd(x, mf(x), 1);
      axi_wr(4'h0, 32'(cm[i]));
      rd(x, mf(x), 1);
      chk(32'(got_ab), 32'(cm[i][7]));
      chk(32'(got_it), 32'(cm[i] == 8'h00));
      if (i == 0)
        rchk(4'h4, 32'hFFFF, 32'hE0);
    end
    // A wrong tag parity this time, so the tag check is reached too.
    x = 22'h001100;
    axi_wr(4'h0, 32'h400);
    rd(x, mf(x), 1);
    axi_wr(4'h0, 32'h0);
    rd(x, mf(x), 1);
    chk(32'(got_ab | got_it), 32'h0);
    rchk(4'h4, 32'hFFFF, 32'h80C0);
    rd(x, mf(x), 0);
    $display("test parity errors ended");
    final_report();
  end
endmodule
`default_nettype wire
